// [hdl/kmgf_filter.sv]
/*
 * kmgf_filter: ghost-key rejection for a scanned 8x8 key matrix.
 * assumes: scan_valid pulses once per complete, consistent snapshot.
 */
`default_nettype none
module kmgf_filter
    import kmgf_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // scanned matrix
    input wire logic [63:0] matrix_input_bytes,
    input wire logic scan_valid,
    // consumer side
    output logic [63:0] key_data_q,
    output logic key_update_q,
    output logic keys_valid_q,
    output logic ghost_seen_q
);
    kmgf_verdict_t verdict;
    logic [63:0] key_data_d;
    logic key_update_d;
    logic keys_valid_d;
    logic ghost_seen_d;

    // verdict for the snapshot on the input
    kmgf_judge u_judge (
        .matrix_input_bytes(matrix_input_bytes),
        .verdict(verdict),
        .line_union_byte(),
        .union_minus_sum_byte()
    );

    // next output state, updated only on a scan
    always_comb begin
        key_data_d = key_data_q;
        key_update_d = 1'b0;
        keys_valid_d = keys_valid_q;
        ghost_seen_d = ghost_seen_q;
        if (scan_valid) begin
            key_update_d = 1'b1;
            if (verdict == KMGF_INVALID) begin
                key_data_d = KMGF_KEYS_RESET;
                keys_valid_d = 1'b0;
                ghost_seen_d = 1'b1;
            end else begin
                key_data_d = matrix_input_bytes;
                keys_valid_d = 1'b1;
                ghost_seen_d = 1'b0;
            end
        end
    end

    // output registers
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            key_data_q <= KMGF_KEYS_RESET;
            key_update_q <= 1'b0;
            keys_valid_q <= 1'b0;
            ghost_seen_q <= 1'b0;
        end else begin
            key_data_q <= key_data_d;
            key_update_q <= key_update_d;
            keys_valid_q <= keys_valid_d;
            ghost_seen_q <= ghost_seen_d;
        end
    end

    // checks
    invalid_blanks_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        scan_valid && verdict == KMGF_INVALID |=> key_data_q == KMGF_KEYS_RESET && ghost_seen_q)
        else $error("invalid pattern was forwarded");
    valid_passes_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        scan_valid && verdict != KMGF_INVALID |=> key_data_q == $past(matrix_input_bytes) && keys_valid_q)
        else $error("valid pattern not forwarded");
    recover_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        ghost_seen_q && scan_valid && verdict == KMGF_VALID |=> !ghost_seen_q && keys_valid_q)
        else $error("no recovery after release");
    hold_between_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        !scan_valid |=> $stable(key_data_q) && !key_update_q)
        else $error("outputs changed without a scan");
    none_zero_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        matrix_input_bytes == KMGF_KEYS_RESET |-> verdict == KMGF_NONE)
        else $error("empty matrix not reported as none");
    three_lines_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        $countones(u_judge.line_union_byte) >= 3 |-> verdict == KMGF_INVALID)
        else $error("three active lines accepted");
    two_line_ghost_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        $countones(u_judge.line_union_byte) == 2 && u_judge.union_minus_sum_byte != 8'h00
        |-> verdict == KMGF_INVALID)
        else $error("two lines with stacked keys accepted");
    one_line_pair_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        $countones(u_judge.line_union_byte) == 1 && u_judge.union_minus_sum_byte != 8'h00
        |-> (verdict == KMGF_VALID) == (8'(u_judge.line_union_byte + u_judge.union_minus_sum_byte) == 8'h00))
        else $error("single line pair judged wrong");
    clean_valid_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        u_judge.line_union_byte != 8'h00 && $countones(u_judge.line_union_byte) <= 2
        && u_judge.union_minus_sum_byte == 8'h00 |-> verdict == KMGF_VALID)
        else $error("clean pattern rejected");
    update_pulse_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        scan_valid |=> key_update_q)
        else $error("scan not acknowledged");

    // in the cycle after each scan, the two status levels tell the same story
    status_exclusive_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        key_update_q |-> keys_valid_q != ghost_seen_q)
        else $error("valid and ghost flags disagree");
    // an empty matrix is forwarded as all-zero data, not flagged
    none_forwards_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        scan_valid && verdict == KMGF_NONE |=> keys_valid_q && !ghost_seen_q && key_data_q == KMGF_KEYS_RESET)
        else $error("empty matrix not forwarded as none");
    // while flagged, the consumer never sees key data
    ghost_blank_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        ghost_seen_q |-> key_data_q == KMGF_KEYS_RESET && !keys_valid_q)
        else $error("key data visible while ghosted");

    // main scenarios
    cover_valid_c: cover property (@(posedge clk_sys) disable iff (!nrst) scan_valid && verdict == KMGF_VALID);
    cover_none_c: cover property (@(posedge clk_sys) disable iff (!nrst) scan_valid && verdict == KMGF_NONE);
    cover_back2back_c: cover property (@(posedge clk_sys) disable iff (!nrst) scan_valid ##1 scan_valid);
    cover_ghost_c: cover property (@(posedge clk_sys) disable iff (!nrst) scan_valid && verdict == KMGF_INVALID);
    cover_recover_c: cover property (@(posedge clk_sys) disable iff (!nrst)
        ghost_seen_q && scan_valid && verdict == KMGF_VALID);
endmodule : kmgf_filter
`default_nettype wire

// [hdl/kmgf_judge.sv]
/*
 * kmgf_judge: combinational verdict on one 8x8 matrix snapshot.
 * assumes: the snapshot is stable for the cycle it is judged in.
 */
`default_nettype none
module kmgf_judge
    import kmgf_pkg::*;
(
    // snapshot in, one byte per common
    input wire logic [63:0] matrix_input_bytes,
    // verdict out
    output var kmgf_verdict_t verdict,
    output logic [7:0] line_union_byte,
    output logic [7:0] union_minus_sum_byte
);
    logic [7:0] sum_byte;
    logic [3:0] line_count;
    logic [7:0] fold_byte;

    // union, wrapping sum and active line count
    always_comb begin
        line_union_byte = KMGF_ZERO_BYTE;
        sum_byte = KMGF_ZERO_BYTE;
        line_count = 4'h0;
        for (int c = 0; c < KMGF_COMMONS; c++) begin
            line_union_byte = line_union_byte | matrix_input_bytes[c*8 +: 8];
            sum_byte = 8'(sum_byte + matrix_input_bytes[c*8 +: 8]);
        end
        for (int b = 0; b < KMGF_LINES; b++) begin
            line_count = 4'(line_count + {3'b000, line_union_byte[b]});
        end
        union_minus_sum_byte = 8'(line_union_byte - sum_byte);
        fold_byte = 8'(line_union_byte + union_minus_sum_byte);
    end

    // judgments one to four
    always_comb begin
        if (line_union_byte == KMGF_ZERO_BYTE) begin
            verdict = KMGF_NONE;
        end else if (line_count > KMGF_MAX_LINES) begin
            verdict = KMGF_INVALID;
        end else if (union_minus_sum_byte == KMGF_ZERO_BYTE) begin
            verdict = KMGF_VALID;
        end else if (line_count == KMGF_MAX_LINES) begin
            verdict = KMGF_INVALID;
        end else if (fold_byte == KMGF_ZERO_BYTE) begin
            verdict = KMGF_VALID;
        end else begin
            verdict = KMGF_INVALID;
        end
    end
endmodule : kmgf_judge
`default_nettype wire

// [pkg/kmgf_pkg.sv]
/*
 * kmgf_pkg: shared constants for the key matrix ghost filter.
 * assumes: one 40 MHz clock domain; no software-visible registers.
 */
`default_nettype none
package kmgf_pkg;
    localparam int KMGF_LINES = 8;    // data lines per common
    localparam int KMGF_COMMONS = 8;  // commons, one byte each
    localparam logic [7:0] KMGF_ZERO_BYTE = 8'h00;
    localparam logic [63:0] KMGF_KEYS_RESET = 64'h0000_0000_0000_0000;
    localparam logic [3:0] KMGF_MAX_LINES = 4'h2;  // more active lines than this is invalid
    typedef enum logic [1:0] {
        KMGF_NONE,
        KMGF_VALID,
        KMGF_INVALID
    } kmgf_verdict_t;
endpackage : kmgf_pkg
`default_nettype wire

// [verification/kmgf_matrix_model.sv]
/*
 * kmgf_matrix_model: scanned key matrix feeding the ghost filter.
 * assumes: the bench raises scan_req at a falling edge; bytes are only meaningful under scan_valid.
 */
`default_nettype none
module kmgf_matrix_model (
    // bench side
    input wire logic clk_sys,
    input wire logic scan_req,
    input wire logic [63:0] key_set,
    // filter side
    output logic [63:0] matrix_input_bytes,
    output logic scan_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    initial matrix_input_bytes = 64'h0000_0000_0000_0000;
    initial scan_valid = 1'b0;
    // one snapshot per request, byte c = common c; outside it the bytes churn
    always @(negedge clk_sys) begin
        scan_valid <= scan_req;
        matrix_input_bytes <= scan_req ? key_set : ~matrix_input_bytes;
    end
endmodule : kmgf_matrix_model
`default_nettype wire

// [verification/tb_top.sv]
/*
 * tb_top: self-checking bench for the key matrix ghost filter.
 * assumes: 40 MHz clk_sys, nrst low for 4 cycles, matrix model in its own file.
 */
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic scan_req = 1'b0;
    logic [63:0] key_set = 64'h0000_0000_0000_0000;
    logic [63:0] matrix_input_bytes, key_data_q;
    logic scan_valid, key_update_q, keys_valid_q, ghost_seen_q;
    int errors = 0;
    int n_compared = 0;
    kmgf_matrix_model model (.clk_sys(clk_sys), .scan_req(scan_req), .key_set(key_set),
        .matrix_input_bytes(matrix_input_bytes), .scan_valid(scan_valid));
    kmgf_filter DUT (.clk_sys(clk_sys), .nrst(nrst), .matrix_input_bytes(matrix_input_bytes),
        .scan_valid(scan_valid), .key_data_q(key_data_q), .key_update_q(key_update_q),
        .keys_valid_q(keys_valid_q), .ghost_seen_q(ghost_seen_q));
    // clock
    initial forever #12.5 clk_sys = ~clk_sys;
    task chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task report_and_stop;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : report_and_stop
    // verdict worked out from union, wrapping sum and difference bytes
    function automatic logic ok_f(input logic [63:0] m);
        logic [7:0] u, s, d;
        u = 8'h00;
        s = 8'h00;
        for (int i = 0; i < 8; i++) begin
            u = u | m[8*i+:8];
            s = s + m[8*i+:8];
        end
        d = u - s;
        if ($countones(u) > 2) return 1'b0;
        if (d == 8'h00) return 1'b1;
        if ($countones(u) == 2) return 1'b0;
        return 8'(u + d) == 8'h00;
    endfunction : ok_f
    // one snapshot through the model, checked at the falling edge half a cycle after it is taken
    // the bytes reach the filter at the second falling edge and are taken at the next rising edge
    task do_scan(input logic [63:0] p, input logic ok);
        chk("rule model", 64'(ok_f(p)), 64'(ok));
        @(negedge clk_sys) key_set <= p;
        scan_req <= 1'b1;
        @(negedge clk_sys) scan_req <= 1'b0;
        @(posedge clk_sys);
        @(negedge clk_sys);
        chk("update", key_update_q, 64'h1);
        chk("valid", keys_valid_q, ok);
        chk("ghost", ghost_seen_q, !ok);
        chk("data", key_data_q, ok ? p : 64'h0);
        @(negedge clk_sys) chk("pulse", key_update_q, 64'h0);
    endtask : do_scan
    task t_none;
        do_scan(64'h0000_0000_0000_0000, 1'b1);
    endtask : t_none
    task t_two_lines;
        do_scan(64'h0000_0000_0010_0004, 1'b1);
        do_scan(64'h8100_0000_0000_0000, 1'b1);
    endtask : t_two_lines
    task t_same_line;
        do_scan(64'h0000_0000_0400_0004, 1'b1);
        do_scan(64'h0000_0004_0400_0004, 1'b0);
        do_scan(64'h0000_0000_0400_0004, 1'b1);
    endtask : t_same_line
    task t_ghosts;
        do_scan(64'h0000_0000_0014_0004, 1'b0);
        do_scan(64'h0000_0000_0020_0014, 1'b0);
        do_scan(64'h0101_0101_0101_0101, 1'b0);
        do_scan(64'h0000_0000_0000_0020, 1'b1);
    endtask : t_ghosts
    // watchdog sized well above the scan sequence
    initial begin
        #(3000 * 25);
        errors++;
        report_and_stop;
    end
    initial begin
        repeat (4) @(negedge clk_sys);
        chk("reset data", key_data_q, 64'h0);
        nrst <= 1'b1;
        t_none;
        t_two_lines;
        t_same_line;
        t_ghosts;
        report_and_stop;
    end
endmodule : tb_top
`default_nettype wire
